/* File: csc_host_model.sv */
`timescale 1ns/1ps
module csc_host_model (
  input  wire logic                  clock_in,
  input  wire csc_pkg::csc_pin_out_t dev_in,
  input  wire logic                  ready_in,
  output csc_pkg::csc_pin_in_t       pins_out
);
  import csc_pkg::*;

  logic bad;

  initial begin
    pins_out = '0;
    pins_out.select_n = 1'b1;
    pins_out.write_strobe_n = 1'b1;
    pins_out.output_gate = 1'b1;
    bad = 1'b0;
  end

  task automatic gate(input logic g, input logic i);
    pins_out.output_gate    <= g;
    pins_out.output_inhibit <= i;
  endtask : gate

  // Hold stretches the high phase, standing in for a slow host
  task automatic run(input logic wr, input logic sn, input logic [5:0] a,
                     input logic [7:0] d, input int hold, output int up,
                     output int dn, output logic [7:0] q, output logic oe);
    logic [8:0] h;
    up = 0;
    dn = 0;
    bad = 1'b0;
    while (ready_in && dn < 64) begin
      @(posedge clock_in);
      dn++;
    end
    pins_out.cycle_strobe   <= 1'b1;
    pins_out.select_n       <= sn;
    pins_out.addr           <= a;
    pins_out.wdata          <= d;
    pins_out.write_strobe_n <= !wr;
    do begin
      @(posedge clock_in);
      up++;
      if (up > 2 && !ready_in && (dev_in.data_oe || dev_in.bitline_assist_latch)) bad = 1'b1;
      if (up > 2 && dev_in.bitline_balancer) bad = 1'b1;
    end while (!ready_in && up < 64);
    q  = dev_in.rdata;
    oe = dev_in.data_oe;
    repeat (hold) @(posedge clock_in);
    pins_out.cycle_strobe   <= 1'b0;
    pins_out.write_strobe_n <= 1'b0;
    pins_out.addr           <= ~a;
    pins_out.wdata          <= ~d;
    dn = 0;
    do begin
      @(posedge clock_in);
      dn++;
      if (dn == 1) h = {dev_in.data_oe, dev_in.rdata};
      if (h !== {dev_in.data_oe, dev_in.rdata}) bad = 1'b1;
    end while (ready_in && dn < 64);
  endtask : run
endmodule : csc_host_model

/* File: csc_pkg.sv */
package csc_pkg;
  localparam int ADDR_W = 6;
  localparam int DATA_W = 8;
  localparam int DEPTH  = 64;
  localparam int CNT_W  = 4;

  // Register byte offsets
  localparam logic [3:0] REG_CTRL   = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_CYCLES = 4'h8;

  // Control fields
  localparam int CTRL_ACC_LSB = 0;
  localparam int CTRL_PRE_LSB = 8;
  localparam logic [CNT_W-1:0] ACC_DLY_RST = 4'h3;
  localparam logic [CNT_W-1:0] PRE_DLY_RST = 4'h2;

  // Status fields
  localparam int STAT_ADDR_LSB = 0;
  localparam int STAT_READY    = 8;
  localparam int STAT_SEL      = 9;
  localparam int STAT_ST_LSB   = 12;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    ST_PRESET  = 2'b00,
    ST_DECODE  = 2'b01,
    ST_ACCESS  = 2'b10,
    ST_RECOVER = 2'b11
  } csc_state_t;

  typedef struct packed {
    logic              cycle_strobe;
    logic              select_n;
    logic              write_strobe_n;
    logic              output_gate;
    logic              output_inhibit;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } csc_pin_in_t;

  typedef struct packed {
    logic              bitline_balancer;
    logic              bitline_assist_latch;
    logic              row_decode_strobe;
    logic              data_oe;
    logic [DATA_W-1:0] rdata;
  } csc_pin_out_t;
endpackage : csc_pkg

/* File: csc_sram_ctrl.sv */
// Implementation choices: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ps
// Function
// - Balance bit lines only while strobe low
// - Assist latch on only after reference timing
// - Reference row fires every cycle
// - One column per data pair, no strobe
// - Address held, sensed data reaches output
// - Strobe fall isolates register, data kept
// - Strobe rise turns output off until access
// - Latched deselect keeps output off
// - Output on only when all gates agree
// - Write needs select, strobe high, write low
// - Write strobe never gates output buffer
// - Status comes from reference timing path
// - Status always driven, even deselected
// - Preset closes address, rows inactive
// - Strobe rise captures address, closes window
// - Status rises when output data valid
// - Status falls only after preset completes
module csc_sram_ctrl (
  input  wire logic                 clock_in,
  input  wire logic                 rst_n_in,
  input  wire logic                 clk_en_in,
  input  wire csc_pkg::csc_pin_in_t pins_in,
  output csc_pkg::csc_pin_out_t     pins_out,
  output logic                      status_ready_out,
  input  wire logic [31:0]          s_axi_awaddr_in,
  input  wire logic                 s_axi_awvalid_in,
  output logic                      s_axi_awready_out,
  input  wire logic [31:0]          s_axi_wdata_in,
  input  wire logic [3:0]           s_axi_wstrb_in,
  input  wire logic                 s_axi_wvalid_in,
  output logic                      s_axi_wready_out,
  output logic [1:0]                s_axi_bresp_out,
  output logic                      s_axi_bvalid_out,
  input  wire logic                 s_axi_bready_in,
  input  wire logic [31:0]          s_axi_araddr_in,
  input  wire logic                 s_axi_arvalid_in,
  output logic                      s_axi_arready_out,
  output logic [31:0]               s_axi_rdata_out,
  output logic [1:0]                s_axi_rresp_out,
  output logic                      s_axi_rvalid_out,
  input  wire logic                 s_axi_rready_in
);
  import csc_pkg::*;

  function automatic logic [1:0] reg_index(input logic [31:0] a);
    if (a[31:4] != 28'h000_0000 || a[1:0] != 2'b00) begin
      return 2'd3;
    end
    unique case (a[3:0])
      REG_CTRL:   return 2'd0;
      REG_STATUS: return 2'd1;
      REG_CYCLES: return 2'd2;
      default:    return 2'd3;
    endcase
  endfunction : reg_index

  logic [DATA_W-1:0] mem [DEPTH];

  csc_state_t        st_r, st_nxt;
  logic              ce_r, ce_nxt;
  logic [ADDR_W-1:0] addr_r, addr_nxt;
  logic              sel_r, sel_nxt;
  logic [CNT_W-1:0]  cnt_r, cnt_nxt;
  logic              dvalid_r, dvalid_nxt;
  logic              status_r, status_nxt;
  csc_pin_out_t      out_r, out_nxt;
  logic [CNT_W-1:0]  acc_dly_r, acc_dly_nxt;
  logic [CNT_W-1:0]  pre_dly_r, pre_dly_nxt;
  logic [15:0]       cycles_r, cycles_nxt;
  logic              wr_en;
  logic              rise;

  logic              aw_got_r, aw_got_nxt;
  logic              w_got_r, w_got_nxt;
  logic [31:0]       waddr_r, waddr_nxt;
  logic [31:0]       wdata_r, wdata_nxt;
  logic [3:0]        wstrb_r, wstrb_nxt;
  logic              awready_r, awready_nxt;
  logic              wready_r, wready_nxt;
  logic              bvalid_r, bvalid_nxt;
  logic [1:0]        bresp_r, bresp_nxt;
  logic              arready_r, arready_nxt;
  logic              rvalid_r, rvalid_nxt;
  logic [1:0]        rresp_r, rresp_nxt;
  logic [31:0]       rdata_r, rdata_nxt;
  logic [31:0]       status_word;

  assign rise  = pins_in.cycle_strobe && !ce_r;
  // Write strobe is only looked at in the decode and access phases
  assign wr_en = sel_r && pins_in.cycle_strobe && !pins_in.write_strobe_n &&
                 (st_r == ST_DECODE || st_r == ST_ACCESS);

  always_comb begin
    st_nxt     = st_r;
    ce_nxt     = pins_in.cycle_strobe;
    addr_nxt   = addr_r;
    sel_nxt    = sel_r;
    cnt_nxt    = cnt_r;
    dvalid_nxt = dvalid_r;
    cycles_nxt = cycles_r;
    out_nxt    = out_r;
    unique case (st_r)
      ST_PRESET: begin
        if (rise) begin
          addr_nxt   = pins_in.addr;
          sel_nxt    = !pins_in.select_n;
          cnt_nxt    = acc_dly_r;
          dvalid_nxt = 1'b0;
          st_nxt     = ST_DECODE;
        end
      end
      ST_DECODE: begin
        // Reference row delay models select reaching end of row
        if (!pins_in.cycle_strobe) begin
          st_nxt  = ST_RECOVER;
          cnt_nxt = pre_dly_r;
        end else if (cnt_r == '0) begin
          st_nxt        = ST_ACCESS;
          dvalid_nxt    = 1'b1;
          out_nxt.rdata = mem[addr_r];
          cycles_nxt    = cycles_r + 16'h0001;
        end else begin
          cnt_nxt = cnt_r - 4'h1;
        end
      end
      ST_ACCESS: begin
        if (!pins_in.cycle_strobe) begin
          st_nxt  = ST_RECOVER;
          cnt_nxt = pre_dly_r;
        end else begin
          out_nxt.rdata = mem[addr_r];
        end
      end
      ST_RECOVER: begin
        if (cnt_r == '0) begin
          st_nxt = ST_PRESET;
        end else begin
          cnt_nxt = cnt_r - 4'h1;
        end
      end
    endcase
    // Balancer only in preset phases with the strobe low
    out_nxt.bitline_balancer = !pins_in.cycle_strobe &&
                               (st_nxt == ST_PRESET || st_nxt == ST_RECOVER);
    out_nxt.bitline_assist_latch = (st_nxt == ST_ACCESS);
    out_nxt.row_decode_strobe    = (st_nxt == ST_DECODE || st_nxt == ST_ACCESS);
    // Status replicates the data path; it stays driven when deselected
    status_nxt = (st_nxt == ST_ACCESS) ||
                 (st_nxt == ST_RECOVER && status_r);
    // Write strobe deliberately absent from the enable term
    out_nxt.data_oe = dvalid_nxt && sel_nxt && pins_in.output_gate &&
                      !pins_in.output_inhibit;
  end

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_r     <= ST_PRESET;
      ce_r     <= 1'b0;
      addr_r   <= '0;
      sel_r    <= 1'b0;
      cnt_r    <= '0;
      dvalid_r <= 1'b0;
      status_r <= 1'b0;
      out_r    <= '0;
      cycles_r <= '0;
    end else if (clk_en_in) begin
      st_r     <= st_nxt;
      ce_r     <= ce_nxt;
      addr_r   <= addr_nxt;
      sel_r    <= sel_nxt;
      cnt_r    <= cnt_nxt;
      dvalid_r <= dvalid_nxt;
      status_r <= status_nxt;
      out_r    <= out_nxt;
      cycles_r <= cycles_nxt;
    end
  end

  // Array has no reset; contents are undefined until written
  always_ff @(posedge clock_in) begin
    if (clk_en_in && wr_en) begin
      mem[addr_r] <= pins_in.wdata;
    end
  end

  assign pins_out         = out_r;
  assign status_ready_out = status_r;

  always_comb begin
    status_word = '0;
    status_word[STAT_ADDR_LSB +: ADDR_W] = addr_r;
    status_word[STAT_READY]              = status_r;
    status_word[STAT_SEL]                = sel_r;
    status_word[STAT_ST_LSB +: 2]        = st_r;
  end

  always_comb begin
    aw_got_nxt  = aw_got_r;
    w_got_nxt   = w_got_r;
    waddr_nxt   = waddr_r;
    wdata_nxt   = wdata_r;
    wstrb_nxt   = wstrb_r;
    bvalid_nxt  = bvalid_r;
    bresp_nxt   = bresp_r;
    rvalid_nxt  = rvalid_r;
    rresp_nxt   = rresp_r;
    rdata_nxt   = rdata_r;
    acc_dly_nxt = acc_dly_r;
    pre_dly_nxt = pre_dly_r;
    if (s_axi_awvalid_in && awready_r) begin
      aw_got_nxt = 1'b1;
      waddr_nxt  = s_axi_awaddr_in;
    end
    if (s_axi_wvalid_in && wready_r) begin
      w_got_nxt = 1'b1;
      wdata_nxt = s_axi_wdata_in;
      wstrb_nxt = s_axi_wstrb_in;
    end
    if (bvalid_r && s_axi_bready_in) begin
      bvalid_nxt = 1'b0;
    end else if (aw_got_r && w_got_r && !bvalid_r) begin
      aw_got_nxt = 1'b0;
      w_got_nxt  = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt  = RESP_OKAY;
      unique case (reg_index(waddr_r))
        2'd0: begin
          if (wstrb_r[0]) begin
            acc_dly_nxt = wdata_r[CTRL_ACC_LSB +: CNT_W];
          end
          if (wstrb_r[1]) begin
            pre_dly_nxt = wdata_r[CTRL_PRE_LSB +: CNT_W];
          end
        end
        2'd1, 2'd2: ;
        2'd3: bresp_nxt = RESP_SLVERR;
      endcase
    end
    if (rvalid_r && s_axi_rready_in) begin
      rvalid_nxt = 1'b0;
    end else if (s_axi_arvalid_in && arready_r) begin
      rvalid_nxt = 1'b1;
      rresp_nxt  = RESP_OKAY;
      rdata_nxt  = '0;
      unique case (reg_index(s_axi_araddr_in))
        2'd0: begin
          rdata_nxt[CTRL_ACC_LSB +: CNT_W] = acc_dly_r;
          rdata_nxt[CTRL_PRE_LSB +: CNT_W] = pre_dly_r;
        end
        2'd1: rdata_nxt = status_word;
        2'd2: rdata_nxt[15:0] = cycles_r;
        2'd3: rresp_nxt = RESP_SLVERR;
      endcase
    end
    awready_nxt = !aw_got_nxt && !bvalid_nxt;
    wready_nxt  = !w_got_nxt && !bvalid_nxt;
    arready_nxt = !rvalid_nxt;
  end

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      aw_got_r  <= 1'b0;
      w_got_r   <= 1'b0;
      waddr_r   <= '0;
      wdata_r   <= '0;
      wstrb_r   <= '0;
      awready_r <= 1'b0;
      wready_r  <= 1'b0;
      bvalid_r  <= 1'b0;
      bresp_r   <= RESP_OKAY;
      arready_r <= 1'b0;
      rvalid_r  <= 1'b0;
      rresp_r   <= RESP_OKAY;
      rdata_r   <= '0;
      acc_dly_r <= ACC_DLY_RST;
      pre_dly_r <= PRE_DLY_RST;
    end else if (clk_en_in) begin
      aw_got_r  <= aw_got_nxt;
      w_got_r   <= w_got_nxt;
      waddr_r   <= waddr_nxt;
      wdata_r   <= wdata_nxt;
      wstrb_r   <= wstrb_nxt;
      awready_r <= awready_nxt;
      wready_r  <= wready_nxt;
      bvalid_r  <= bvalid_nxt;
      bresp_r   <= bresp_nxt;
      arready_r <= arready_nxt;
      rvalid_r  <= rvalid_nxt;
      rresp_r   <= rresp_nxt;
      rdata_r   <= rdata_nxt;
      acc_dly_r <= acc_dly_nxt;
      pre_dly_r <= pre_dly_nxt;
    end
  end

  assign s_axi_awready_out = awready_r;
  assign s_axi_wready_out  = wready_r;
  assign s_axi_bvalid_out  = bvalid_r;
  assign s_axi_bresp_out   = bresp_r;
  assign s_axi_arready_out = arready_r;
  assign s_axi_rvalid_out  = rvalid_r;
  assign s_axi_rresp_out   = rresp_r;
  assign s_axi_rdata_out   = rdata_r;

  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);

  balance_excl_a: assert property (pins_out.bitline_balancer |-> !pins_out.bitline_assist_latch)
    else $error("balancer active with assist latch");
  latch_after_ref_a: assert property ($rose(pins_out.bitline_assist_latch) |->
      $past(st_r) == ST_DECODE && $past(cnt_r) == '0)
    else $error("assist latch before reference timing");
  status_replica_a: assert property ($rose(status_ready_out) |->
      $rose(pins_out.bitline_assist_latch) && pins_out.row_decode_strobe)
    else $error("status not tied to reference timing");
  rise_off_a: assert property (clk_en_in && st_r == ST_PRESET && rise |=> !pins_out.data_oe)
    else $error("output on after strobe rise");
  desel_off_a: assert property (clk_en_in && !sel_r && st_r != ST_PRESET |=>
      !pins_out.data_oe)
    else $error("output on while deselected");
  gate_off_a: assert property (clk_en_in &&
      (!pins_in.output_gate || pins_in.output_inhibit) |=> !pins_out.data_oe)
    else $error("output on with gate off");
  write_cond_a: assert property (wr_en |-> sel_r && pins_in.cycle_strobe &&
      !pins_in.write_strobe_n && pins_out.row_decode_strobe && !pins_out.bitline_balancer)
    else $error("write without all conditions");
  preset_fall_a: assert property ($fell(status_ready_out) |->
      $past(st_r) == ST_RECOVER && st_r == ST_PRESET)
    else $error("status fell before preset done");
  addr_hold_a: assert property (st_r == ST_ACCESS && $past(st_r) == ST_ACCESS |->
      $stable(addr_r) && $stable(sel_r))
    else $error("address moved during active phase");
  axi_resp_a: assert property (clk_en_in && aw_got_r && w_got_r && !bvalid_r |=> bvalid_r)
    else $error("write response late");

  read_cycle_c: cover property ($rose(status_ready_out) ##[1:20] $fell(status_ready_out));
  write_cycle_c: cover property (wr_en ##1 st_r == ST_RECOVER);
  desel_cycle_c: cover property (!sel_r && status_ready_out);
  axi_write_c: cover property (bvalid_r && s_axi_bready_in);
endmodule : csc_sram_ctrl

/* File: csc_sram_ctrl_tb.sv */
`timescale 1ns/1ps
module csc_sram_ctrl_tb;
  import csc_pkg::*;
  logic         clock_in;
  logic         rst_n_in;
  logic         clk_en_in;
  csc_pin_in_t  pins;
  csc_pin_out_t po;
  logic         ready;
  logic [31:0]  awaddr, wdata, araddr, rdata;
  logic [3:0]   wstrb;
  logic         awvalid, wvalid, bready, arvalid, rready;
  logic         awready, wready, bvalid, arready, rvalid;
  logic [1:0]   bresp, rresp;
  int           mismatches;
  int           checks;
  int           up, dn;
  logic [7:0]   q;
  logic         oe;

  csc_sram_ctrl uut (
    .clock_in(clock_in), .rst_n_in(rst_n_in), .clk_en_in(clk_en_in),
    .pins_in(pins), .pins_out(po), .status_ready_out(ready),
    .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
    .s_axi_wdata_in(wdata), .s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid),
    .s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid),
    .s_axi_bready_in(bready), .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
    .s_axi_arready_out(arready), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
    .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready)
  );

  csc_host_model host (
    .clock_in(clock_in), .dev_in(po), .ready_in(ready), .pins_out(pins)
  );

  initial begin
    clock_in = 1'b0;
    forever #12.5 clock_in = ~clock_in;
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic axi_write(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge clock_in);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge clock_in);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid && n < 64);
    if (n == 64) mismatches++;
    r = bresp;
    bready <= 1'b0;
  endtask : axi_write

  task automatic axi_read(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge clock_in);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge clock_in);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid && n < 64);
    if (n == 64) mismatches++;
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : axi_read

  task automatic t_regs();
    logic [31:0] d;
    logic [1:0]  r;
    axi_read(32'h0000_0000, d, r);
    chk("ctrl reset", 32'h0000_0203, d);
    axi_read(32'h0000_0010, d, r);
    chk("unmapped resp", 32'(RESP_SLVERR), 32'(r));
    axi_write(32'h0000_0000, 32'h0000_0101, r);
    chk("write resp", 32'(RESP_OKAY), 32'(r));
    axi_read(32'h0000_0000, d, r);
    chk("ctrl readback", 32'h0000_0101, d);
    $display("test regs done");
  endtask : t_regs

  task automatic t_timing();
    logic [1:0] r;
    host.run(1'b0, 1'b0, 6'h01, 8'h00, 0, up, dn, q, oe);
    chk("access edges", 32'h4, 32'(up));
    chk("preset edges", 32'h4, 32'(dn));
    axi_write(32'h0000_0000, 32'h0000_0203, r);
    chk("write resp", 32'(RESP_OKAY), 32'(r));
    host.run(1'b0, 1'b0, 6'h01, 8'h00, 3, up, dn, q, oe);
    chk("access edges", 32'(ACC_DLY_RST) + 32'h3, 32'(up));
    chk("preset edges", 32'(PRE_DLY_RST) + 32'h3, 32'(dn));
    $display("test timing done");
  endtask : t_timing

  task automatic t_rw();
    host.run(1'b1, 1'b0, 6'h2a, 8'ha5, 0, up, dn, q, oe);
    host.run(1'b1, 1'b0, 6'h15, 8'h5a, 2, up, dn, q, oe);
    host.run(1'b0, 1'b0, 6'h2a, 8'h00, 0, up, dn, q, oe);
    chk("read data", 32'h00a5, 32'(q));
    chk("oe at ready", 32'h1, 32'(oe));
    chk("pin timing", 32'h0, 32'(host.bad));
    host.run(1'b0, 1'b0, 6'h15, 8'h00, 1, up, dn, q, oe);
    chk("read data", 32'h005a, 32'(q));
    $display("test rw done");
  endtask : t_rw

  task automatic t_desel();
    logic [31:0] d;
    logic [1:0]  r;
    host.run(1'b1, 1'b1, 6'h2a, 8'h3c, 0, up, dn, q, oe);
    chk("desel status", 32'(ACC_DLY_RST) + 32'h3, 32'(up));
    chk("desel oe", 32'h0, 32'(oe));
    host.run(1'b0, 1'b0, 6'h2a, 8'h00, 0, up, dn, q, oe);
    chk("no desel write", 32'h00a5, 32'(q));
    // Two timing, four read/write, one deselected write and one read cycle so far; deselected ones count too
    axi_read(32'h0000_0008, d, r);
    chk("cycle count", 32'h0000_0008, d);
    $display("test desel done");
  endtask : t_desel

  task automatic t_gates();
    logic [31:0] d;
    logic [1:0]  r;
    axi_read(32'h0000_0004, d, r);
    chk("status reg", 32'h0000_022a, d);
    host.gate(1'b0, 1'b0);
    repeat (3) @(posedge clock_in);
    chk("oe gate low", 32'h0, 32'(po.data_oe));
    host.gate(1'b1, 1'b1);
    repeat (3) @(posedge clock_in);
    chk("oe inhibit", 32'h0, 32'(po.data_oe));
    host.gate(1'b1, 1'b0);
    repeat (3) @(posedge clock_in);
    chk("oe write low", 32'h1, 32'(po.data_oe));
    chk("balancer", 32'h1, 32'(po.bitline_balancer));
    chk("row strobe", 32'h0, 32'(po.row_decode_strobe));
    chk("assist", 32'h0, 32'(po.bitline_assist_latch));
    // A frozen clock must keep the output on although the gate has dropped
    clk_en_in <= 1'b0;
    host.gate(1'b0, 1'b0);
    repeat (3) @(posedge clock_in);
    chk("oe frozen", 32'h1, 32'(po.data_oe));
    clk_en_in <= 1'b1;
    host.gate(1'b1, 1'b0);
    repeat (2) @(posedge clock_in);
    chk("oe thawed", 32'h1, 32'(po.data_oe));
    $display("test gates done");
  endtask : t_gates

  task automatic test_done();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : test_done

  // Whole run is under two hundred cycles; the limit of 20000 cycles leaves a wide margin
  initial begin
    #500000;
    mismatches++;
    test_done();
  end

  initial begin
    mismatches = 0;
    checks = 0;
    clk_en_in = 1'b1;
    rst_n_in = 1'b0;
    {awaddr, wdata, araddr} = '0;
    wstrb = 4'hf;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    repeat (6) @(posedge clock_in);
    rst_n_in <= 1'b1;
    @(posedge clock_in);
    t_regs();
    t_timing();
    t_rw();
    t_desel();
    t_gates();
    test_done();
  end
endmodule : csc_sram_ctrl_tb
